// File: row_repair_consts.svh
// timing counts, field positions and guard key values for row repair entry
`ifndef ROW_REPAIR_CONSTS_SVH
`define ROW_REPAIR_CONSTS_SVH

`define MR_ADDR_W          4
`define CA_ADDR_W          18
`define MR0_SEL            4'h0
`define MR4_SEL            4'h4
`define MR4_HARD_BIT       13
`define MR4_SOFT_BIT       5
`define KEY_LEN            4
`define KEY_ENTRY0         18'h00B7F
`define KEY_ENTRY1         18'h007FF
`define KEY_ENTRY2         18'h00BFF
`define KEY_ENTRY3         18'h003FF
`define BANK_GROUPS        2
`define ROW_W              16
`define CMD_GAP_CYC        4'h4

`endif

// File: row_repair_pkg.sv
// types shared by both ends of the row repair entry link
package row_repair_pkg;
  typedef enum logic [3:0] {
    CMD_DES = 4'h0,
    CMD_MRS = 4'h1,
    CMD_ACT = 4'h2,
    CMD_WR  = 4'h3,
    CMD_WRA = 4'h4,
    CMD_RD  = 4'h5,
    CMD_PRE = 4'h6,
    CMD_REF = 4'h7,
    CMD_ZQ  = 4'h8,
    CMD_NOP = 4'h9,
    CMD_RFU = 4'hA
  } cmd_t;
endpackage

// File: row_repair_if.sv
// command link from controller to device
`include "row_repair_consts.svh"
interface row_repair_if;
  import row_repair_pkg::*;
  logic                      cmd_valid;
  cmd_t                      cmd;
  logic [`MR_ADDR_W-1:0]     mr_sel;
  logic [1:0]                bg;
  logic [1:0]                ba;
  logic [`CA_ADDR_W-1:0]     addr;
  modport ctrl (output cmd_valid, cmd, mr_sel, bg, ba, addr);
  modport dev  (input  cmd_valid, cmd, mr_sel, bg, ba, addr);
endinterface

// File: row_repair_ctrl.sv
// controller end: issues mode set, guard key and one repair sequence
`include "row_repair_consts.svh"
module row_repair_ctrl (
  input  wire logic                      clock_in,
  input  wire logic                      rst_in,
  input  wire logic                      start_in,
  input  wire logic                      hard_in,
  input  wire logic                      use_wra_in,
  input  wire logic [0:0]                bg_in,
  input  wire logic [1:0]                ba_in,
  input  wire logic [`ROW_W-1:0]         row_in,
  output logic                           busy_out,
  output logic                           done_out,
  row_repair_if.ctrl                     link
);
  import row_repair_pkg::*;

  // ----------------------------------------
  // sequence state
  // ----------------------------------------
  typedef enum logic [3:0] {
    S_IDLE = 4'b0000, S_MR4 = 4'b0001, S_K0 = 4'b0010, S_K1 = 4'b0011,
    S_K2 = 4'b0100, S_K3 = 4'b0101, S_ACT = 4'b0110, S_WR = 4'b0111,
    S_REF = 4'b1000, S_EXIT = 4'b1001, S_DONE = 4'b1010
  } state_t;

  state_t          state;
  state_t          next_state;
  logic            hard;
  logic            wra;
  logic [3:0]      gap;
  wire             gap_done = (gap == 4'h0);
  // mode choice for the mode write, taken live on the start edge
  wire             hard_now = (state == S_IDLE) ? hard_in : hard;

  // step order; key entries leave no gap between them
  always_comb begin
    next_state = state;
    case (state)
      S_IDLE:  if (start_in) next_state = S_MR4;
      S_MR4:   next_state = S_K0;
      S_K0:    next_state = S_K1;
      S_K1:    next_state = S_K2;
      S_K2:    next_state = S_K3;
      S_K3:    next_state = S_ACT;
      S_ACT:   if (gap_done) next_state = S_WR;
      S_WR:    if (gap_done) next_state = wra ? S_REF : S_EXIT;
      S_REF:   if (gap_done) next_state = S_EXIT;
      S_EXIT:  next_state = S_DONE;
      S_DONE:  next_state = S_IDLE;
      default: next_state = S_IDLE;
    endcase
  end

  // state, options and gap counter
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state <= S_IDLE;
      hard  <= 1'b0;
      wra   <= 1'b0;
      gap   <= 4'h0;
    end else begin
      state <= next_state;
      if (state == S_IDLE && start_in) begin
        hard <= hard_in;
        wra  <= use_wra_in;
      end
      gap <= (next_state != state) ? `CMD_GAP_CYC : (gap_done ? 4'h0 : gap - 4'h1);
    end
  end

  // command outputs, registered
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      link.cmd_valid <= 1'b0;
      link.cmd       <= CMD_DES;
      link.mr_sel    <= 4'h0;
      link.bg        <= 2'h0;
      link.ba        <= 2'h0;
      link.addr      <= '0;
      busy_out       <= 1'b0;
      done_out       <= 1'b0;
    end else begin
      link.cmd_valid <= 1'b0;
      link.cmd       <= CMD_DES;
      busy_out       <= (next_state != S_IDLE);
      done_out       <= (next_state == S_DONE);
      link.bg        <= {1'b0, bg_in};
      link.ba        <= ba_in;
      // mode bit, four key entries, then activate, write, refresh only after a write with auto precharge, and mode exit
      if (next_state != state || (gap_done && next_state != S_IDLE)) begin
        case (next_state)
          S_MR4: begin
            link.cmd_valid <= 1'b1;
            link.cmd       <= CMD_MRS;
            link.mr_sel    <= `MR4_SEL;
            link.addr      <= '0;
            link.addr[`MR4_HARD_BIT] <= hard_now;
            link.addr[`MR4_SOFT_BIT] <= ~hard_now;
          end
          S_K0, S_K1, S_K2, S_K3: begin
            link.cmd_valid <= 1'b1;
            link.cmd       <= CMD_MRS;
            link.mr_sel    <= `MR0_SEL;
            link.addr      <= (next_state == S_K0) ? `KEY_ENTRY0 :
                              (next_state == S_K1) ? `KEY_ENTRY1 :
                              (next_state == S_K2) ? `KEY_ENTRY2 : `KEY_ENTRY3;
          end
          S_ACT: if (next_state != state) begin
            link.cmd_valid <= 1'b1;
            link.cmd       <= CMD_ACT;
            link.addr      <= {2'b00, row_in};
          end
          // write with or without auto precharge
          S_WR: if (next_state != state) begin
            link.cmd_valid <= 1'b1;
            link.cmd       <= wra ? CMD_WRA : CMD_WR;
          end
          S_REF: if (next_state != state) begin
            link.cmd_valid <= 1'b1;
            link.cmd       <= CMD_REF;
          end
          S_EXIT: begin
            link.cmd_valid <= 1'b1;
            link.cmd       <= CMD_MRS;
            link.mr_sel    <= `MR4_SEL;
            link.addr      <= '0;
          end
          default: ;
        endcase
      end
    end
  end
endmodule

// File: row_repair_dev.sv
// device end: guard key check and row repair fuse sequencing
`include "row_repair_consts.svh"
module row_repair_dev (
  input  wire logic                          clock_in,
  input  wire logic                          rst_in,
  row_repair_if.dev                          link,
  output logic                               hard_mode_out,
  output logic                               soft_mode_out,
  output logic                               armed_out,
  output logic [`BANK_GROUPS-1:0]            fuse_used_out,
  output logic [`BANK_GROUPS*`ROW_W-1:0]     fuse_row_out,
  output logic                               soft_valid_out,
  output logic [`ROW_W-1:0]                  soft_row_out,
  output logic                               soft_bg_out,
  output logic                               normal_act_out,
  output logic                               normal_wr_out,
  output logic [`ROW_W-1:0]                  open_row_out,
  output logic [1:0]                         open_ba_out,
  output logic                               open_bg_out
);
  import row_repair_pkg::*;

  // ----------------------------------------
  // command decode
  // ----------------------------------------
  function automatic logic [`CA_ADDR_W-1:0] key_value(input logic [2:0] pos);
    case (pos)
      3'h0:    key_value = `KEY_ENTRY0;
      3'h1:    key_value = `KEY_ENTRY1;
      3'h2:    key_value = `KEY_ENTRY2;
      default: key_value = `KEY_ENTRY3;
    endcase
  endfunction

  // ----------------------------------------
  // held state
  // ----------------------------------------
  // key progress, a broken-key latch and an armed activate
  logic [2:0]  key_pos;
  logic        key_dead;
  logic        act_pending;

  // ----------------------------------------
  // command classes
  // ----------------------------------------
  // a deselect is no command and never breaks the key
  wire         cmd_seen   = link.cmd_valid && link.cmd != CMD_DES;
  wire         is_mrs     = cmd_seen && link.cmd == CMD_MRS;
  wire         mr4_write  = is_mrs && link.mr_sel == `MR4_SEL;
  wire         set_hard   = mr4_write && link.addr[`MR4_HARD_BIT];
  wire         set_soft   = mr4_write && link.addr[`MR4_SOFT_BIT];
  wire         in_mode    = hard_mode_out || soft_mode_out;
  // one key check for both modes
  wire         key_match  = is_mrs && link.mr_sel == `MR0_SEL &&
                            link.addr == key_value(key_pos);
  // the key is open from a mode write until it arms or breaks
  wire         key_active = in_mode && !armed_out && !key_dead &&
                            key_pos < 3'(`KEY_LEN);
  wire         key_step   = key_active && cmd_seen;
  wire         key_last   = (key_pos == 3'(`KEY_LEN - 1));
  // activates and writes, plain or with auto precharge
  wire         is_act     = cmd_seen && link.cmd == CMD_ACT;
  wire         is_wr      = cmd_seen && (link.cmd == CMD_WR || link.cmd == CMD_WRA);
  // repair commands exist only while armed; a write with no
  // armed activate before it must never burn a fuse
  wire         rep_act    = armed_out && is_act;
  wire         rep_wr     = armed_out && act_pending && is_wr;
  // a hard repair needs its group's fuse still free
  wire         hard_bg_free = !fuse_used_out[open_bg_out];
  wire         hard_take    = rep_wr && hard_mode_out && hard_bg_free;
  wire         soft_take    = rep_wr && soft_mode_out;

  // ----------------------------------------
  // repair mode bits
  // ----------------------------------------
  // every mode register 4 write sets or clears both bits;
  // the hard bit wins when a write sets both
  // clearing both bits also disarms and closes the key
  wire         next_hard_mode = mr4_write ? set_hard : hard_mode_out;
  wire         next_soft_mode = mr4_write ? (set_soft && !set_hard) : soft_mode_out;

  // mode bit registers
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      hard_mode_out <= 1'b0;
      soft_mode_out <= 1'b0;
    end else begin
      hard_mode_out <= next_hard_mode;
      soft_mode_out <= next_soft_mode;
    end
  end

  // ----------------------------------------
  // guard key tracking
  // ----------------------------------------
  // counter advances on match, clears on any other command while the key is open or on any mode register 4 write, holds otherwise
  // the position stops at four once armed
  wire  [2:0]  next_key_pos  = mr4_write ? 3'h0 :
                               !key_step ? key_pos :
                               key_match ? key_pos + 3'h1 : 3'h0;
  // any other command kills the key
  // a dead key stays dead until the next mode write, so a retry
  // without a fresh mode write can never arm the repair
  wire         next_key_dead = mr4_write ? 1'b0 : (key_dead || (key_step && !key_match));
  // arming needs all four entries back to back
  wire         next_armed    = mr4_write ? 1'b0 :
                               (key_step && key_match && key_last) ? 1'b1 : armed_out;

  // key position, dead latch and armed flag
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      key_pos   <= 3'h0;
      key_dead  <= 1'b0;
      armed_out <= 1'b0;
    end else begin
      key_pos   <= next_key_pos;
      key_dead  <= next_key_dead;
      armed_out <= next_armed;
    end
  end

  // ----------------------------------------
  // activate capture and array commands
  // ----------------------------------------
  // unarmed act/write go to the array
  wire         next_normal_act  = is_act && !armed_out;
  wire         next_normal_wr   = is_wr && !rep_wr;
  // an armed activate waits for its write; a write or mode change drops it
  wire         next_act_pending = is_act ? rep_act :
                                  (is_wr || mr4_write) ? 1'b0 : act_pending;

  // array command pulses, one cycle each;
  // a repair write is kept from the array
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      normal_act_out <= 1'b0;
      normal_wr_out  <= 1'b0;
      act_pending    <= 1'b0;
    end else begin
      normal_act_out <= next_normal_act;
      normal_wr_out  <= next_normal_wr;
      act_pending    <= next_act_pending;
    end
  end

  // row, bank and group of the last activate,
  // captured on every activate, armed or not, for the repair write
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      open_row_out <= '0;
      open_ba_out  <= 2'h0;
      open_bg_out  <= 1'b0;
    end else if (is_act) begin
      open_row_out <= link.addr[`ROW_W-1:0];
      open_ba_out  <= link.ba;
      open_bg_out  <= link.bg[0];
    end
  end

  // ----------------------------------------
  // hard repair fuses
  // ----------------------------------------
  // each group's fuse written once, cleared only by reset
  // repair taken on the write of either sequence
  // a fused group ignores later hard repairs, the first row stays;
  // the slot of group g starts at bit g times the row width
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      fuse_used_out <= '0;
      fuse_row_out  <= '0;
    end else if (hard_take) begin
      fuse_used_out[open_bg_out] <= 1'b1;
      fuse_row_out[open_bg_out*`ROW_W +: `ROW_W] <= open_row_out;
    end
  end

  // ----------------------------------------
  // soft repair latch
  // ----------------------------------------
  // no status output on a failed key
  // holds one row, replaced by the next soft repair;
  // like the fuses it is lost on reset
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      soft_valid_out <= 1'b0;
      soft_row_out   <= '0;
      soft_bg_out    <= 1'b0;
    end else if (soft_take) begin
      soft_valid_out <= 1'b1;
      soft_row_out   <= open_row_out;
      soft_bg_out    <= open_bg_out;
    end
  end
endmodule

// File: row_repair_guard_entry_asserts.sv
// link checker: mode set, guard key order and repair sequence shape
`include "row_repair_consts.svh"
module row_repair_guard_entry_asserts (
  input wire logic                  clock_in,
  input wire logic                  rst_in,
  input wire logic                  cmd_valid,
  input wire row_repair_pkg::cmd_t  cmd,
  input wire logic [`MR_ADDR_W-1:0] mr_sel,
  input wire logic [1:0]            bg,
  input wire logic [1:0]            ba,
  input wire logic [`CA_ADDR_W-1:0] addr
);
  timeunit 1ns;
  timeprecision 1ps;
  import row_repair_pkg::*;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  // decoded mode register writes
  wire logic is_mr4 = cmd_valid && cmd == CMD_MRS && mr_sel == `MR4_SEL;
  wire logic mode_on = addr[`MR4_HARD_BIT] | addr[`MR4_SOFT_BIT];
  sequence s_mr0(logic [`CA_ADDR_W-1:0] v);
    cmd_valid && cmd == CMD_MRS && mr_sel == `MR0_SEL && addr == v;
  endsequence
  sequence s_key;
    s_mr0(`KEY_ENTRY0) ##1 s_mr0(`KEY_ENTRY1) ##1 s_mr0(`KEY_ENTRY2) ##1 s_mr0(`KEY_ENTRY3);
  endsequence
  sequence s_act_gap;
    (cmd_valid && cmd == CMD_ACT) ##1 (!cmd_valid)[*4];
  endsequence
  sequence s_wr_bank;
    cmd_valid && (cmd == CMD_WR || cmd == CMD_WRA) && ba == $past(ba, 5) && bg == $past(bg, 5);
  endsequence
  a_wr_same_bank: assert property (s_act_gap |=> s_wr_bank)
    else $error("repair write left the activated bank");
  a_key_after_mode: assert property (is_mr4 && mode_on |=> s_key)
    else $error("guard key does not follow mode set");
  a_key_order_one: assert property (s_mr0(`KEY_ENTRY0) |=> s_mr0(`KEY_ENTRY1))
    else $error("second key entry missing");
  a_key_order_two: assert property (s_mr0(`KEY_ENTRY1) |=> s_mr0(`KEY_ENTRY2))
    else $error("third key entry missing");
  a_key_order_three: assert property (s_mr0(`KEY_ENTRY2) |=> s_mr0(`KEY_ENTRY3))
    else $error("fourth key entry missing");
  a_act_after_key: assert property (s_key |-> ##[1:16] (cmd_valid && cmd == CMD_ACT))
    else $error("no activate after guard key");
  a_wra_then_ref: assert property (cmd_valid && cmd == CMD_WRA |-> ##[1:16] (cmd_valid && cmd == CMD_REF))
    else $error("no refresh after auto precharge write");
  a_wr_no_ref: assert property (cmd_valid && cmd == CMD_WR |=> (!(cmd_valid && cmd == CMD_REF))[*8])
    else $error("refresh inside plain write sequence");
  a_mode_cleared: assert property (cmd_valid && (cmd == CMD_WR || cmd == CMD_REF) |-> ##[1:16] (is_mr4 && !mode_on))
    else $error("repair mode not cleared after sequence");
endmodule

// File: row_repair_guard_entry_tb.sv
// bench: controller and device joined, plus a device driven directly
`include "row_repair_consts.svh"
module row_repair_guard_entry_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import row_repair_pkg::*;
  logic             clock_in = 1'b0;
  logic             rst_in = 1'b1;
  logic             start, hard, use_wra, bgi, busy, done, hm, sm, arm, sv, sbg, obg;
  logic             arm2, sm2, nwr2, sv2, nact2;
  logic [1:0]       bai, used, used2, oba;
  logic [15:0]      row, srow, srow2, orow2;
  logic [31:0]      frow;
  logic [1:0]       m_used = 2'h0;
  logic [15:0]      m_row [2] = '{16'h0, 16'h0};
  logic [15:0]      m_srow = 16'h0;
  logic             m_sv = 1'b0;
  logic             m_sbg = 1'b0;
  logic [17:0]      keys [4] = '{`KEY_ENTRY0, `KEY_ENTRY1, `KEY_ENTRY2, `KEY_ENTRY3};
  int               fails = 0;
  int               num_checks = 0;
  row_repair_if link ();
  row_repair_if link2 ();
  // clock at 4 ns
  always #2 clock_in = ~clock_in;
  row_repair_ctrl i_row_repair_ctrl (.clock_in(clock_in), .rst_in(rst_in), .start_in(start),
    .hard_in(hard), .use_wra_in(use_wra), .bg_in(bgi), .ba_in(bai), .row_in(row),
    .busy_out(busy), .done_out(done), .link(link));
  row_repair_dev i_row_repair_dev (.clock_in(clock_in), .rst_in(rst_in), .link(link),
    .hard_mode_out(hm), .soft_mode_out(sm), .armed_out(arm), .fuse_used_out(used),
    .fuse_row_out(frow), .soft_valid_out(sv), .soft_row_out(srow), .soft_bg_out(sbg),
    .normal_act_out(), .normal_wr_out(), .open_row_out(), .open_ba_out(oba),
    .open_bg_out(obg));
  row_repair_dev i_row_repair_dev_2 (.clock_in(clock_in), .rst_in(rst_in), .link(link2),
    .hard_mode_out(), .soft_mode_out(sm2), .armed_out(arm2), .fuse_used_out(used2),
    .fuse_row_out(), .soft_valid_out(sv2), .soft_row_out(srow2), .soft_bg_out(),
    .normal_act_out(nact2), .normal_wr_out(nwr2), .open_row_out(orow2), .open_ba_out(),
    .open_bg_out());
  row_repair_guard_entry_asserts i_row_repair_guard_entry_asserts (.clock_in(clock_in),
    .rst_in(rst_in), .cmd_valid(link.cmd_valid), .cmd(link.cmd), .mr_sel(link.mr_sel),
    .bg(link.bg), .ba(link.ba), .addr(link.addr));
  // compare one result
  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %0h seen %0h", name, exp, got);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // one command on the directly driven link, held one cycle
  task automatic send(cmd_t c, logic [3:0] s, logic [17:0] a);
    link2.cmd_valid = 1'b1;
    link2.cmd = c;
    link2.mr_sel = s;
    link2.addr = a;
    @(negedge clock_in);
  endtask
  // one full controller run, then model update and compare
  task automatic run(logic h, logic w, logic b);
    int n;
    hard = h;
    use_wra = w;
    bgi = b;
    bai = 2'($urandom);
    row = 16'($urandom);
    start = 1'b1;
    @(negedge clock_in);
    start = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 400) begin
      @(negedge clock_in);
      n++;
    end
    if (n >= 400) begin
      fails++;
      wrap_up();
    end
    if (h) begin
      if (m_used[b] == 1'b0) m_row[b] = row;
      m_used[b] = 1'b1;
    end else begin
      m_sv = 1'b1;
      m_srow = row;
      m_sbg = b;
    end
    repeat (2) @(negedge clock_in);
    chk("fuse used", 32'(m_used), 32'(used));
    chk("fuse rows", {m_row[1], m_row[0]}, frow);
    chk("soft row", 32'({m_sv, m_sbg, m_srow}), 32'({sv, sbg, srow}));
    chk("modes", 32'h0, 32'({busy, hm, sm, arm}));
    chk("open bank", 32'({b, bai}), 32'({obg, oba}));
    $display("test hard=%0d wra=%0d bg=%0d done", h, w, b);
  endtask
  initial begin
    {start, hard, use_wra, bgi, bai, row} = '0;
    {link2.cmd_valid, link2.mr_sel, link2.bg, link2.ba, link2.addr} = '0;
    link2.cmd = CMD_DES;
    void'($urandom(42260));
    repeat (16) @(negedge clock_in);
    rst_in = 1'b0;
    // both sequences, a second repair on a fused group, soft both ways
    run(1'b1, 1'b1, 1'b0);
    run(1'b1, 1'b0, 1'b1);
    run(1'b1, 1'b1, 1'b0);
    run(1'b0, 1'b0, 1'b1);
    run(1'b0, 1'b1, 1'b0);
    // broken key: a no-operation after the second entry
    send(CMD_MRS, `MR4_SEL, 18'h1 << `MR4_HARD_BIT);
    for (int i = 0; i < 4; i++) begin
      send(CMD_MRS, `MR0_SEL, keys[i]);
      if (i == 1) send(CMD_NOP, 4'h0, 18'h0);
    end
    // a full key without a fresh mode write must not arm
    for (int i = 0; i < 4; i++) send(CMD_MRS, `MR0_SEL, keys[i]);
    chk("armed broken", 32'h0, 32'(arm2));
    send(CMD_ACT, 4'h0, 18'h00ABC);
    chk("normal act", 32'h1, 32'(nact2));
    send(CMD_WR, 4'h0, 18'h0);
    chk("normal write", 32'h1, 32'(nwr2));
    chk("open row", 32'h0ABC, 32'(orow2));
    chk("no fuse", 32'h0, 32'(used2));
    send(CMD_MRS, `MR4_SEL, 18'h0);
    $display("test broken key done");
    // correct key in soft mode
    send(CMD_MRS, `MR4_SEL, 18'h1 << `MR4_SOFT_BIT);
    for (int i = 0; i < 4; i++) send(CMD_MRS, `MR0_SEL, keys[i]);
    chk("armed soft", 32'h3, 32'({sm2, arm2}));
    send(CMD_ACT, 4'h0, 18'h0F0F0);
    chk("repair act", 32'h0, 32'(nact2));
    send(CMD_WR, 4'h0, 18'h0);
    chk("soft repair", 32'h1F0F0, 32'({nwr2, sv2, srow2}));
    send(CMD_MRS, `MR4_SEL, 18'h0);
    link2.cmd_valid = 1'b0;
    link2.cmd = CMD_DES;
    @(negedge clock_in);
    chk("disarmed", 32'h0, 32'({sm2, arm2}));
    $display("test soft key done");
    wrap_up();
  end
endmodule
